// ### logic/bsp_defines.svh
// Constants of the buffered serial port configuration block.
// Assumes a 16-bit peripheral bus with a 5-bit word address.
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define BSP_ADDR_PIN_CTRL   5'h00
`define BSP_ADDR_RATE_GEN2  5'h01
`define BSP_ADDR_TX_MC2     5'h02
`define BSP_ADDR_RX_MC2     5'h03
`define BSP_ADDR_FORMAT     5'h04
`define BSP_ADDR_STATUS     5'h05
`define BSP_ADDR_CHAN_BIT   4
`define BSP_ADDR_CHAN_RX    3

// ****************************************************************
// Field positions
// ****************************************************************
`define BSP_PCR_TX_GPIO     13
`define BSP_PCR_RX_GPIO     12
`define BSP_PCR_TX_FMODE    11
`define BSP_PCR_RX_FMODE    10
`define BSP_PCR_TX_CMODE    9
`define BSP_PCR_RX_CMODE    8
`define BSP_PCR_EXTEND      7
`define BSP_PCR_EXT_CLOCK_PIN_STATUS   6
`define BSP_PCR_TXD_STAT    5
`define BSP_PCR_RXD_STAT    4
`define BSP_PCR_TX_FPOL     3
`define BSP_PCR_RX_FPOL     2
`define BSP_PCR_TX_CPOL     1
`define BSP_PCR_RX_CPOL     0
`define BSP_MC_EXT_BIT      9
`define BSP_RG2_SRC_BIT     13
`define BSP_FMT_CLKSTOP     3
`define BSP_FMT_PHASE       4

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define BSP_PCR_RESET       16'h0000
`define BSP_PCR_WMASK       16'h3fff
`define BSP_RG2_RESET       16'h2000
`define BSP_RG2_WMASK       16'h20ff
`define BSP_MC_RESET        16'h0000
`define BSP_MC_WMASK        16'h0200
`define BSP_FMT_RESET       16'h0000
`define BSP_FMT_WMASK       16'h0fff
`define BSP_CHAN_RESET      16'h0000

`endif

// ### logic/bsp_pkg.sv
// Types of the buffered serial port configuration block.
// Assumes bsp_defines.svh for all numeric constants.
`default_nettype none

package bsp_pkg;

  // Serial pins sampled from outside the CPU clock domain
  typedef struct packed {
    logic tx_clk;
    logic rx_clk;
    logic tx_fs;
    logic rx_fs;
    logic rx_data;
  } bsp_pins_t;

  // Sample-rate generator input
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_CPU,
    SRC_RXPIN,
    SRC_TXPIN
  } bsp_src_t;

endpackage

`default_nettype wire

// ### logic/bsp_pin_sync.sv
// Two-stage synchroniser with edge detect for the serial pins.
// Assumes pins are asynchronous to CLK and slower than CLK/2.
`timescale 1ns/1ps
`default_nettype none

module bsp_pin_sync (
  // Clock and reset
  input  wire  logic                  clk,
  input  wire  logic                  resetn,
  // Raw pins
  input  wire  bsp_pkg::bsp_pins_t    pins_in,
  // Synchronised view
  output logic [4:0]                  level,
  output logic [4:0]                  rise,
  output logic [4:0]                  fall
);

  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic [4:0] prev_reg;
  logic [4:0] pin_vec;

  assign pin_vec = pins_in;

  // ****************************************************************
  // Per-pin stages
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < 5; i++) begin : g_pin
      // First stage feeds only the second stage
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
          prev_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= pin_vec[i];
          sync_reg[i] <= meta_reg[i];
          prev_reg[i] <= sync_reg[i];
        end
      end
      assign level[i] = sync_reg[i];
      assign rise[i]  = sync_reg[i] & ~prev_reg[i];
      assign fall[i]  = ~sync_reg[i] & prev_reg[i];
    end
  endgenerate

endmodule

`default_nettype wire

// ### logic/bsp_config.sv
// Buffered serial port clock, frame and channel configuration.
// Assumes a single-cycle peripheral bus on CLK; pin levels are
// resolved from the output enables by the surroundings.
`timescale 1ns/1ps
`default_nettype none
`include "bsp_defines.svh"

module bsp_config (
  // Clock and reset
  input  wire  logic        CLK,
  input  wire  logic        RESETN,
  // Peripheral bus
  input  wire  logic [4:0]  BUS_ADDR,
  input  wire  logic        BUS_WR,
  input  wire  logic        BUS_RD,
  input  wire  logic [15:0] BUS_WDATA,
  output logic       [15:0] BUS_RDATA,
  // Clock pins
  input  wire  logic        TX_CLK_IN,
  output logic              TX_CLK_OUT,
  output logic              TX_CLK_OE,
  input  wire  logic        RX_CLK_IN,
  output logic              RX_CLK_OUT,
  output logic              RX_CLK_OE,
  // Frame sync pins
  input  wire  logic        TX_FS_IN,
  output logic              TX_FS_OUT,
  output logic              TX_FS_OE,
  input  wire  logic        RX_FS_IN,
  output logic              RX_FS_OUT,
  output logic              RX_FS_OE,
  // Data pins
  output logic              TX_DATA_OUT,
  output logic              TX_DATA_OE,
  input  wire  logic        RX_DATA_IN,
  // Channel state
  output logic              TX_CH_ACTIVE,
  output logic              RX_CH_ACTIVE,
  output logic       [6:0]  CH_SLOT
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [5:0] word_bits(input logic [2:0] code);
    unique case (code)
      3'h0:    word_bits = 6'h08;
      3'h1:    word_bits = 6'h0c;
      3'h2:    word_bits = 6'h10;
      3'h3:    word_bits = 6'h14;
      3'h4:    word_bits = 6'h18;
      default: word_bits = 6'h20;
    endcase
  endfunction

  function automatic logic chan_on(input logic [127:0] bank,
                                   input logic [6:0]   slot,
                                   input logic         ext);
    chan_on = ext ? bank[slot] : bank[{2'b00, slot[4:0]}];
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  bsp_pkg::bsp_pins_t pins;
  logic [4:0]         p_lvl;
  logic [4:0]         p_rise;
  logic [4:0]         p_fall;

  assign pins = '{tx_clk: TX_CLK_IN, rx_clk: RX_CLK_IN, tx_fs: TX_FS_IN,
                  rx_fs: RX_FS_IN, rx_data: RX_DATA_IN};

  bsp_pin_sync u_sync (
    .clk     (CLK),
    .resetn  (RESETN),
    .pins_in (pins),
    .level   (p_lvl),
    .rise    (p_rise),
    .fall    (p_fall)
  );

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [15:0] pcr_reg, pcr_next;
  logic [15:0] rg2_reg, rg2_next;
  logic [15:0] txmc_reg, txmc_next;
  logic [15:0] rxmc_reg, rxmc_next;
  logic [15:0] fmt_reg, fmt_next;
  logic [15:0] chan_reg [16];
  logic [15:0] chan_next [16];
  logic [15:0] rdata_next;
  logic [15:0] status;
  logic [15:0] pcr_view;

  always_comb begin
    pcr_next  = pcr_reg;
    rg2_next  = rg2_reg;
    txmc_next = txmc_reg;
    rxmc_next = rxmc_reg;
    fmt_next  = fmt_reg;
    for (int k = 0; k < 16; k++) begin
      chan_next[k] = chan_reg[k];
    end
    if (BUS_WR) begin
      if (BUS_ADDR[`BSP_ADDR_CHAN_BIT]) begin
        chan_next[BUS_ADDR[3:0]] = BUS_WDATA;
      end else begin
        unique case (BUS_ADDR)
          `BSP_ADDR_PIN_CTRL:  pcr_next  = BUS_WDATA & `BSP_PCR_WMASK;
          `BSP_ADDR_RATE_GEN2: rg2_next  = BUS_WDATA & `BSP_RG2_WMASK;
          `BSP_ADDR_TX_MC2:    txmc_next = BUS_WDATA & `BSP_MC_WMASK;
          `BSP_ADDR_RX_MC2:    rxmc_next = BUS_WDATA & `BSP_MC_WMASK;
          `BSP_ADDR_FORMAT:    fmt_next  = BUS_WDATA & `BSP_FMT_WMASK;
          default: ;
        endcase
      end
    end
  end

  // Received data status reads the pin while the receive side is GPIO
  always_comb begin
    pcr_view = pcr_reg;
    if (pcr_reg[`BSP_PCR_RX_GPIO]) begin
      pcr_view[`BSP_PCR_RXD_STAT] = p_lvl[0];
    end
  end

  always_comb begin
    rdata_next = 16'h0000;
    if (BUS_RD) begin
      if (BUS_ADDR[`BSP_ADDR_CHAN_BIT]) begin
        rdata_next = chan_reg[BUS_ADDR[3:0]];
      end else begin
        unique case (BUS_ADDR)
          `BSP_ADDR_PIN_CTRL:  rdata_next = pcr_view;
          `BSP_ADDR_RATE_GEN2: rdata_next = rg2_reg;
          `BSP_ADDR_TX_MC2:    rdata_next = txmc_reg;
          `BSP_ADDR_RX_MC2:    rdata_next = rxmc_reg;
          `BSP_ADDR_FORMAT:    rdata_next = fmt_reg;
          `BSP_ADDR_STATUS:    rdata_next = status;
          default:             rdata_next = 16'h0000;
        endcase
      end
    end
  end

  // Plain flops with no refresh: state holds at any clock rate
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pcr_reg   <= `BSP_PCR_RESET;
      rg2_reg   <= `BSP_RG2_RESET;
      txmc_reg  <= `BSP_MC_RESET;
      rxmc_reg  <= `BSP_MC_RESET;
      fmt_reg   <= `BSP_FMT_RESET;
      BUS_RDATA <= 16'h0000;
      for (int k = 0; k < 16; k++) begin
        chan_reg[k] <= `BSP_CHAN_RESET;
      end
    end else begin
      pcr_reg   <= pcr_next;
      rg2_reg   <= rg2_next;
      txmc_reg  <= txmc_next;
      rxmc_reg  <= rxmc_next;
      fmt_reg   <= fmt_next;
      BUS_RDATA <= rdata_next;
      for (int k = 0; k < 16; k++) begin
        chan_reg[k] <= chan_next[k];
      end
    end
  end

  // ****************************************************************
  // Effective configuration
  // ****************************************************************
  bsp_pkg::bsp_src_t src;
  logic              clk_stop;
  logic              phase_eff;
  logic [6:0]        words_m1;
  logic [5:0]        wl;
  logic              tx_cmode, rx_cmode, tx_fmode, rx_fmode;
  logic              tx_gpio, rx_gpio;

  always_comb begin
    unique case ({pcr_reg[`BSP_PCR_EXTEND], rg2_reg[`BSP_RG2_SRC_BIT]})
      2'b00: src = bsp_pkg::SRC_NONE;
      2'b01: src = bsp_pkg::SRC_CPU;
      2'b10: src = bsp_pkg::SRC_RXPIN;
      2'b11: src = bsp_pkg::SRC_TXPIN;
    endcase
  end

  assign clk_stop  = fmt_reg[`BSP_FMT_CLKSTOP];
  assign phase_eff = clk_stop ? 1'b0 : fmt_reg[`BSP_FMT_PHASE];
  assign words_m1  = clk_stop ? 7'h00 : fmt_reg[11:5];
  assign wl        = word_bits(fmt_reg[2:0]);
  assign tx_cmode  = pcr_reg[`BSP_PCR_TX_CMODE];
  assign tx_fmode  = pcr_reg[`BSP_PCR_TX_FMODE];
  // SPI operation: receiver follows the transmitter's role
  assign rx_cmode  = clk_stop ? tx_cmode : pcr_reg[`BSP_PCR_RX_CMODE];
  assign rx_fmode  = clk_stop ? tx_fmode : pcr_reg[`BSP_PCR_RX_FMODE];
  assign tx_gpio   = pcr_reg[`BSP_PCR_TX_GPIO];
  assign rx_gpio   = pcr_reg[`BSP_PCR_RX_GPIO];
  assign status    = {6'h00, phase_eff, words_m1 == 7'h00, src, CH_SLOT[5:0]};

  // ****************************************************************
  // Sample-rate generator and frame timing
  // ****************************************************************
  logic       tick, bit_tick, fs_ext, div_end;
  logic [7:0] div_reg, div_next;
  logic       srg_reg, srg_next;
  logic [4:0] bit_reg, bit_next;
  logic [6:0] slot_reg, slot_next;
  logic       fs_reg, fs_next;
  logic       word_end;

  // Pin edges honour the polarity bits
  always_comb begin
    unique case (src)
      bsp_pkg::SRC_CPU:   tick = 1'b1;
      bsp_pkg::SRC_RXPIN: tick = pcr_reg[`BSP_PCR_RX_CPOL] ? p_fall[3] : p_rise[3];
      bsp_pkg::SRC_TXPIN: tick = pcr_reg[`BSP_PCR_TX_CPOL] ? p_fall[4] : p_rise[4];
      default:            tick = 1'b0;
    endcase
    fs_ext   = pcr_reg[`BSP_PCR_TX_FPOL] ? p_fall[2] : p_rise[2];
    bit_tick = tx_cmode ? (tick && div_end && !srg_reg)
                        : (pcr_reg[`BSP_PCR_TX_CPOL] ? p_fall[4] : p_rise[4]);
  end

  // Compare with >= so a divider or word length lowered mid-count
  // wraps at once instead of running on to the counter's overflow
  assign div_end  = div_reg >= rg2_reg[7:0];
  assign word_end = bit_tick && ({1'b0, bit_reg} >= wl - 6'h01);

  always_comb begin
    div_next  = div_reg;
    srg_next  = srg_reg;
    bit_next  = bit_reg;
    slot_next = slot_reg;
    fs_next   = 1'b0;
    if (tick) begin
      div_next = div_end ? 8'h00 : div_reg + 8'h01;
      srg_next = div_end ? ~srg_reg : srg_reg;
    end
    if (!tx_fmode && fs_ext) begin
      bit_next  = 5'h00;
      slot_next = 7'h00;
    end else if (word_end) begin
      bit_next  = 5'h00;
      slot_next = (slot_reg >= words_m1) ? 7'h00 : slot_reg + 7'h01;
      fs_next   = tx_fmode && (slot_reg >= words_m1);
    end else if (bit_tick) begin
      bit_next  = bit_reg + 5'h01;
    end else if ({1'b0, bit_reg} >= wl) begin
      // A shorter word length restarts the word in progress
      bit_next  = 5'h00;
    end
    if (clk_stop) begin
      slot_next = 7'h00;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_reg  <= 8'h00;
      srg_reg  <= 1'b0;
      bit_reg  <= 5'h00;
      slot_reg <= 7'h00;
      fs_reg   <= 1'b0;
    end else begin
      div_reg  <= div_next;
      srg_reg  <= srg_next;
      bit_reg  <= bit_next;
      slot_reg <= slot_next;
      fs_reg   <= fs_next;
    end
  end

  // ****************************************************************
  // Pin drivers and channel flags
  // ****************************************************************
  logic [127:0] tx_bank, rx_bank;
  logic         txco_n, txcoe_n, rxco_n, rxcoe_n;
  logic         txfo_n, txfoe_n, rxfo_n, rxfoe_n;
  logic         txd_n, txdoe_n, txa_n, rxa_n;

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      tx_bank[k*16 +: 16] = chan_reg[k];
      rx_bank[k*16 +: 16] = chan_reg[k+8];
    end
    txa_n   = chan_on(tx_bank, slot_reg, txmc_reg[`BSP_MC_EXT_BIT]);
    rxa_n   = chan_on(rx_bank, slot_reg, rxmc_reg[`BSP_MC_EXT_BIT]);
    // Generator drives whichever clock pin is not its own input
    txco_n  = srg_reg ^ pcr_reg[`BSP_PCR_TX_CPOL];
    txcoe_n = tx_cmode && !tx_gpio && src != bsp_pkg::SRC_TXPIN;
    rxco_n  = srg_reg ^ pcr_reg[`BSP_PCR_RX_CPOL];
    rxcoe_n = rx_cmode && !rx_gpio && src != bsp_pkg::SRC_RXPIN;
    txfo_n  = fs_reg ^ pcr_reg[`BSP_PCR_TX_FPOL];
    txfoe_n = tx_fmode && !tx_gpio;
    rxfo_n  = fs_reg ^ pcr_reg[`BSP_PCR_RX_FPOL];
    rxfoe_n = rx_fmode && !rx_gpio;
    txd_n   = tx_gpio && pcr_reg[`BSP_PCR_TXD_STAT];
    txdoe_n = tx_gpio;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      TX_CLK_OUT   <= 1'b0;
      TX_CLK_OE    <= 1'b0;
      RX_CLK_OUT   <= 1'b0;
      RX_CLK_OE    <= 1'b0;
      TX_FS_OUT    <= 1'b0;
      TX_FS_OE     <= 1'b0;
      RX_FS_OUT    <= 1'b0;
      RX_FS_OE     <= 1'b0;
      TX_DATA_OUT  <= 1'b0;
      TX_DATA_OE   <= 1'b0;
      TX_CH_ACTIVE <= 1'b0;
      RX_CH_ACTIVE <= 1'b0;
      CH_SLOT      <= 7'h00;
    end else begin
      TX_CLK_OUT   <= txco_n;
      TX_CLK_OE    <= txcoe_n;
      RX_CLK_OUT   <= rxco_n;
      RX_CLK_OE    <= rxcoe_n;
      TX_FS_OUT    <= txfo_n;
      TX_FS_OE     <= txfoe_n;
      RX_FS_OUT    <= rxfo_n;
      RX_FS_OE     <= rxfoe_n;
      TX_DATA_OUT  <= txd_n;
      TX_DATA_OE   <= txdoe_n;
      TX_CH_ACTIVE <= txa_n;
      RX_CH_ACTIVE <= rxa_n;
      CH_SLOT      <= slot_reg;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_pcr_read;
    BUS_RD && BUS_ADDR == `BSP_ADDR_PIN_CTRL && !rx_gpio;
  endsequence

  chk_legacy_block: assert property (
    !txmc_reg[`BSP_MC_EXT_BIT] && chan_reg[0] == 16'h0000
      && chan_reg[1] == 16'h0000 |=> !TX_CH_ACTIVE)
    else $error("legacy mode enabled a channel outside blocks");
  chk_ext_all_on: assert property (
    rxmc_reg[`BSP_MC_EXT_BIT] && rx_bank[slot_reg] |=> RX_CH_ACTIVE)
    else $error("extended mode missed an enabled channel");
  chk_clkstop_frame: assert property (
    clk_stop |=> (slot_reg == 7'h00) || !$past(clk_stop))
    else $error("clock-stop frame holds more than one word");
  chk_word_bound: assert property (
    {1'b0, bit_reg} < wl || $changed(fmt_reg[2:0]))
    else $error("bit counter exceeds word length");
  chk_spi_role: assert property (
    clk_stop && !tx_gpio && !rx_gpio && src == bsp_pkg::SRC_CPU
      |=> RX_CLK_OE == TX_CLK_OE)
    else $error("SPI roles of transmitter and receiver differ");
  chk_cpu_source: assert property (
    !pcr_reg[`BSP_PCR_EXTEND] && rg2_reg[`BSP_RG2_SRC_BIT]
      && rg2_reg[7:0] == 8'h00 |=> $changed(srg_reg))
    else $error("CPU clock not feeding the generator");
  chk_rxpin_quiet: assert property (
    src == bsp_pkg::SRC_RXPIN |=> !RX_CLK_OE)
    else $error("receive clock driven while it feeds the generator");
  chk_pcr_read: assert property (
    s_pcr_read |=> BUS_RDATA == $past(pcr_reg))
    else $error("pin control readback mismatch");
  chk_ext_frame: assert property (
    !tx_fmode ##1 !tx_fmode |-> !TX_FS_OE)
    else $error("frame sync driven in external mode");

endmodule

`default_nettype wire

// ### dv/bsp_link_partner.sv
// Far-side serial partner: a codec that drives the link clock,
// a frame pulse every sixteen bits and a static data level.
// Assumes the bench resolves the shared pins from the enables.
`timescale 1ns/1ps
`default_nettype none

module bsp_link_partner (
  // Bench control
  input  wire logic run,
  input  wire logic data_lvl,
  // Link side
  output var  logic link_clk,
  output var  logic frame_sync,
  output wire logic data_out
);
  int unsigned bit_cnt;

  // Clock stands still between bursts, as a real codec would
  initial begin
    link_clk = 1'b0;
    frame_sync = 1'b0;
    bit_cnt = 0;
    #37;
    forever begin
      if (run) begin
        #200 link_clk = 1'b1;
        frame_sync = (bit_cnt == 0);
        bit_cnt = (bit_cnt + 1) % 16;
        #200 link_clk = 1'b0;
      end else begin
        link_clk = 1'b0;
        frame_sync = 1'b0;
        #50;
      end
    end
  end

  assign data_out = data_lvl;
endmodule

`default_nettype wire

// ### dv/serial_port_clock_channel_config_tb.sv
// Self-checking bench for the serial port configuration block.
// Assumes bsp_link_partner drives every clock and frame pin the block releases.
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, e, g) begin n_tests++; if ((g) !== (e)) begin \
  err_total++; \
  $display("mismatch %s exp %0h got %0h", what, e, g); end end

module serial_port_clock_channel_config_tb;
  typedef struct packed {
    logic        w;
    logic [4:0]  a;
    logic [15:0] v;
    logic [15:0] e;
  } bsp_row_t;

  logic        clk, resetn, bus_wr, bus_rd;
  logic [4:0]  bus_addr;
  logic [15:0] bus_wdata, bus_rdata, d;
  logic        tx_clk_out, tx_clk_oe, rx_clk_out, rx_clk_oe;
  logic        tx_fs_out, tx_fs_oe, rx_fs_out, rx_fs_oe;
  logic        tx_data_out, tx_data_oe, tx_ch_active, rx_ch_active;
  logic [6:0]  ch_slot;
  logic        p_run, p_data, p_clk, p_fs, p_dat;
  wire logic   tx_clk_pin, rx_clk_pin, tx_fs_pin, rx_fs_pin;
  int          err_total, n_tests, n, n_rx;
  int          cyc = 0;
  int          wl [8] = '{8, 12, 16, 20, 24, 32, 32, 32};
  bsp_row_t    rows [14] = '{
    '{1'b0, 5'h00, 16'h0000, 16'h0000}, '{1'b0, 5'h01, 16'h0000, 16'h2000},
    '{1'b0, 5'h02, 16'h0000, 16'h0000}, '{1'b0, 5'h03, 16'h0000, 16'h0000},
    '{1'b0, 5'h04, 16'h0000, 16'h0000}, '{1'b1, 5'h00, 16'hffff, 16'h3fef},
    '{1'b1, 5'h00, 16'h0aa5, 16'h0aa5}, '{1'b1, 5'h01, 16'hffff, 16'h20ff},
    '{1'b1, 5'h02, 16'hffff, 16'h0200}, '{1'b1, 5'h03, 16'hffff, 16'h0200},
    '{1'b1, 5'h04, 16'hffff, 16'h0fff}, '{1'b1, 5'h06, 16'h1234, 16'h0000},
    '{1'b1, 5'h10, 16'ha5a5, 16'ha5a5}, '{1'b1, 5'h1f, 16'h5a5a, 16'h5a5a}};

  // Shared pins: the block wins wherever it enables its driver
  assign tx_clk_pin = tx_clk_oe ? tx_clk_out : p_clk;
  assign rx_clk_pin = rx_clk_oe ? rx_clk_out : p_clk;
  assign tx_fs_pin  = tx_fs_oe ? tx_fs_out : p_fs;
  assign rx_fs_pin  = rx_fs_oe ? rx_fs_out : p_fs;

  bsp_config u_dut (
    .CLK(clk), .RESETN(resetn), .BUS_ADDR(bus_addr), .BUS_WR(bus_wr),
    .BUS_RD(bus_rd), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata),
    .TX_CLK_IN(tx_clk_pin), .TX_CLK_OUT(tx_clk_out), .TX_CLK_OE(tx_clk_oe),
    .RX_CLK_IN(rx_clk_pin), .RX_CLK_OUT(rx_clk_out), .RX_CLK_OE(rx_clk_oe),
    .TX_FS_IN(tx_fs_pin), .TX_FS_OUT(tx_fs_out), .TX_FS_OE(tx_fs_oe),
    .RX_FS_IN(rx_fs_pin), .RX_FS_OUT(rx_fs_out), .RX_FS_OE(rx_fs_oe),
    .TX_DATA_OUT(tx_data_out), .TX_DATA_OE(tx_data_oe),
    .RX_DATA_IN(p_dat), .TX_CH_ACTIVE(tx_ch_active),
    .RX_CH_ACTIVE(rx_ch_active), .CH_SLOT(ch_slot)
  );

  bsp_link_partner u_partner (
    .run(p_run), .data_lvl(p_data), .link_clk(p_clk),
    .frame_sync(p_fs), .data_out(p_dat)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Bus tasks and measurements
  // ****************************************************************
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  // Read data stands one cycle only, so it is taken just after the edge
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask

  task automatic toggles(input int k, output int t);
    logic last;
    t = 0;
    last = tx_clk_out;
    repeat (k) begin
      @(posedge clk);
      #1;
      if (tx_clk_out !== last) t++;
      last = tx_clk_out;
    end
  endtask

  // First change is discarded: it may straddle a format update
  task automatic slot_period(output int t);
    logic [6:0] s;
    int         g;
    g = 0;
    s = ch_slot;
    while (ch_slot === s && g < 300) begin
      @(posedge clk);
      #1 g++;
    end
    s = ch_slot;
    t = 0;
    while (ch_slot === s && t < 300) begin
      @(posedge clk);
      #1 t++;
    end
  endtask

  task automatic wait_slot(input logic [6:0] v);
    int g;
    g = 0;
    while (ch_slot !== v && g < 5000) begin
      @(posedge clk);
      #1 g++;
    end
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Ceiling well above the longest path through the sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      complete_run();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    resetn = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 5'h00;
    bus_wdata = 16'h0000;
    p_run = 1'b0;
    p_data = 1'b0;
    err_total = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    `CHK("reset clk oe", 2'b00, {tx_clk_oe, rx_clk_oe})
    `CHK("reset fs oe", 3'b000, {tx_fs_oe, rx_fs_oe, tx_data_oe})
    resetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].v);
      rd(rows[i].a, d);
      `CHK("reg", rows[i].e, d)
    end
    // Every extend/source pairing, both clock modes driving
    for (int k = 0; k < 4; k++) begin
      wr(5'h00, k[1] ? 16'h0380 : 16'h0300);
      wr(5'h01, k[0] ? 16'h2000 : 16'h0000);
      repeat (4) @(posedge clk);
      rd(5'h05, d);
      `CHK("src", 16'(k) << 6, d & 16'h00c0)
      `CHK("rx oe", k != 2, rx_clk_oe)
      `CHK("tx oe", k != 3, tx_clk_oe)
    end
    wr(5'h01, 16'h0000);
    p_run = 1'b1;
    repeat (20) @(posedge clk);
    toggles(80, n);
    `CHK("rx fed gen", 1'b1, n >= 9 && n <= 11)
    p_run = 1'b0;
    repeat (200) @(posedge clk);
    toggles(40, n);
    `CHK("gen halted", 0, n)
    p_run = 1'b1;
    repeat (20) @(posedge clk);
    toggles(80, n);
    `CHK("gen resumed", 1'b1, n >= 9 && n <= 11)
    p_run = 1'b0;
    wr(5'h00, 16'h3220);
    wr(5'h01, 16'h2000);
    for (int v = 0; v < 2; v++) begin
      p_data = v[0];
      repeat (6) @(posedge clk);
      rd(5'h00, d);
      `CHK("gpio in", v[0], d[4])
    end
    `CHK("gpio out", 3'b110, {tx_data_oe, tx_data_out, tx_clk_oe})
    wr(5'h00, 16'h0200);
    for (int s = 0; s < 2; s++) begin
      wr(5'h04, s[0] ? 16'h0ff0 : 16'h0ff8);
      repeat (4) @(posedge clk);
      rd(5'h05, d);
      `CHK("phase", s[0] ? 16'h0200 : 16'h0100, d & 16'h0300)
      `CHK("spi rx oe", !s[0], rx_clk_oe)
      `CHK("spi rx clk", tx_clk_out, rx_clk_out)
    end
    for (int c = 0; c < 8; c++) begin
      wr(5'h04, 16'h0fe0 | 16'(c));
      slot_period(n);
      slot_period(n);
      `CHK("slot len", wl[c] * 2, n)
    end
    wr(5'h04, 16'h0fe0);
    wr(5'h10, 16'h0000);
    wr(5'h12, 16'hffff);
    wr(5'h18, 16'h0000);
    wr(5'h1a, 16'hffff);
    for (int m = 0; m < 2; m++) begin
      wr(5'h02, m[0] ? 16'h0200 : 16'h0000);
      wr(5'h03, m[0] ? 16'h0000 : 16'h0200);
      wait_slot(7'h28);
      `CHK("chan", {m[0], !m[0]}, {tx_ch_active, rx_ch_active})
    end
    wr(5'h04, 16'h0000);
    for (int p = 0; p < 2; p++) begin
      wr(5'h00, p[0] ? 16'h0e0c : 16'h0e00);
      repeat (4) @(posedge clk);
      n = 0;
      n_rx = 0;
      repeat (64) begin
        @(posedge clk);
        #1;
        if (tx_fs_out === !p[0]) n++;
        if (rx_fs_out === !p[0]) n_rx++;
      end
      `CHK("fs pulses", 4, n)
      `CHK("rx fs pulses", 4, n_rx)
      `CHK("fs oe", 2'b11, {tx_fs_oe, rx_fs_oe})
    end
    wr(5'h00, 16'h0200);
    repeat (4) @(posedge clk);
    `CHK("fs ext", 2'b00, {tx_fs_oe, rx_fs_oe})
    // Mid-run reset: drivers drop and registers return to defaults
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("mid reset oe", 1'b0, tx_clk_oe)
    resetn <= 1'b1;
    rd(5'h02, d);
    `CHK("mid reset mc", 16'h0000, d)
    rd(5'h01, d);
    `CHK("mid reset src", 16'h2000, d)
    complete_run();
  end
endmodule

`default_nettype wire
